// File: csw_pkg.sv
/*
  Constants for the control/status and write-protect block: bus codes,
  field positions of the control byte, reset values, timings and states.
  Assumes a 200 MHz system clock.
*/
package csw_pkg;
  // Counter width for the long hold and store timers
  localparam int CNT_W = 27;
  typedef logic [CNT_W-1:0] csw_cnt_t;

  // Bus codes: target byte for control write, for read, register address
  localparam logic [7:0] DEV_WR = 8'ha4;
  localparam logic [7:0] DEV_RD = 8'ha5;
  localparam logic [7:0] REG_ADDR = 8'hff;

  // Field positions inside the control_status byte
  localparam int BIT_DLY_HI = 7;
  localparam int BIT_MON2 = 6;
  localparam int BIT_MON3 = 5;
  localparam int BIT_LOCK_HI = 4;
  localparam int BIT_LOCK_LO = 3;
  localparam int BIT_REGISTER_WRITE_LATCH = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_DLY_LO = 0;

  // Reset values of the retained fields
  localparam logic [1:0] LOCK_RST = 2'h0;
  localparam logic [1:0] DLY_RST = 2'h1;

  // Lowest locked array address per partition
  localparam logic [7:0] LOCK_QTR_BASE = 8'hc0;
  localparam logic [7:0] LOCK_HALF_BASE = 8'h80;

  // Timings in milliseconds and the clock rate in kHz
  localparam int HOLD0_MS = 50;
  localparam int HOLD1_MS = 100;
  localparam int HOLD2_MS = 200;
  localparam int HOLD3_MS = 300;
  localparam int STORE_MS = 5;
  localparam int CLK_KHZ = 200000;

  // Synchroniser lanes for pin inputs
  localparam int NPIN = 7;
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_SUP = 3;
  localparam int PIN_MR = 4;
  localparam int PIN_MON2 = 5;
  localparam int PIN_MON3 = 6;

  // Serial protocol states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_REG = 4'h2,
    ST_WDATA = 4'h3,
    ST_ACK = 4'h4,
    ST_RDATA = 4'h5,
    ST_RACK = 4'h6
  } csw_state_e;
endpackage : csw_pkg

// File: csw_ctrl.sv
/*
  Control/status register, write enables, region lock, write-protect,
  power-on reset hold and monitor flags, reached over a two-wire serial
  bus. Assumes an open-drain data line resolved outside, the serial clock
  as a second clock, and array/potentiometer logic that asks for leave.
*/
`timescale 1ns/10ps

module csw_ctrl #(
  parameter int unsigned HOLD0_CYC = csw_pkg::HOLD0_MS * csw_pkg::CLK_KHZ,
  parameter int unsigned HOLD1_CYC = csw_pkg::HOLD1_MS * csw_pkg::CLK_KHZ,
  parameter int unsigned HOLD2_CYC = csw_pkg::HOLD2_MS * csw_pkg::CLK_KHZ,
  parameter int unsigned HOLD3_CYC = csw_pkg::HOLD3_MS * csw_pkg::CLK_KHZ,
  parameter int unsigned STORE_CYC = csw_pkg::STORE_MS * csw_pkg::CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect_in,
  input wire logic supply_ok_in,
  input wire logic manual_reset_in,
  input wire logic monitor2_reset_out,
  input wire logic monitor3_reset_out,
  input wire logic wr_req,
  input wire logic [7:0] wr_addr,
  input wire logic wr_to_pot,
  input wire logic wr_nonvol,
  output logic wr_grant,
  output logic wr_deny,
  output logic supply_reset_out,
  output logic [1:0] lock_part,
  output logic [1:0] reset_delay_sel,
  output logic store_busy,
  output logic write_enable_latch,
  output logic register_write_latch
);

  logic [csw_pkg::NPIN-1:0] pin_raw, sync1_q, sync2_q;
  logic scl_d_q, sda_d_q, lbit_q, ltog_q, tsync1_q, tsync2_q, tsync3_q;
  logic start_ev, stop_ev, rise_ev, fall_ev, wp_s, mon2_s, mon3_s;
  csw_pkg::csw_state_e st_q, nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, rd_q, data_q, status;
  logic oe_q, sda_o_q, ptr_ok_q, got_q, commit_q;
  logic wel_q, register_write_latch_q, mon2_flag_q, mon3_flag_q, busy_q;
  logic [1:0] lock_q, dly_q;
  csw_pkg::csw_cnt_t bcnt_q, por_cnt_q, hold_lim;
  logic sro_q, locked_addr, allow, grant_q, deny_q;

  // Pin lanes gathered for the synchroniser
  assign pin_raw[csw_pkg::PIN_SDA] = sda_in;
  assign pin_raw[csw_pkg::PIN_SCL] = scl_clk;
  assign pin_raw[csw_pkg::PIN_WP] = write_protect_in;
  assign pin_raw[csw_pkg::PIN_SUP] = supply_ok_in;
  assign pin_raw[csw_pkg::PIN_MR] = manual_reset_in;
  assign pin_raw[csw_pkg::PIN_MON2] = monitor2_reset_out;
  assign pin_raw[csw_pkg::PIN_MON3] = monitor3_reset_out;

  // Two-flop synchroniser per pin lane
  for (genvar i = 0; i < csw_pkg::NPIN; i++) begin : g_sync
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  assign wp_s = sync2_q[csw_pkg::PIN_WP];
  assign mon2_s = sync2_q[csw_pkg::PIN_MON2];
  assign mon3_s = sync2_q[csw_pkg::PIN_MON3];

  // Link side: capture data on each serial clock rise and flag it by toggle
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      lbit_q <= 1'b0;
      ltog_q <= 1'b0;
    end else begin
      lbit_q <= sda_in;
      ltog_q <= ~ltog_q;
    end
  end

  // Toggle crossing; the captured bit is stable a whole serial period
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tsync1_q <= 1'b0;
      tsync2_q <= 1'b0;
      tsync3_q <= 1'b0;
      scl_d_q <= 1'b0;
      sda_d_q <= 1'b0;
    end else begin
      tsync1_q <= ltog_q;
      tsync2_q <= tsync1_q;
      tsync3_q <= tsync2_q;
      scl_d_q <= sync2_q[csw_pkg::PIN_SCL];
      sda_d_q <= sync2_q[csw_pkg::PIN_SDA];
    end
  end

  // Bus conditions seen on the synchronised lines
  assign rise_ev = tsync2_q ^ tsync3_q;
  assign fall_ev = scl_d_q & ~sync2_q[csw_pkg::PIN_SCL];
  assign start_ev = scl_d_q & sync2_q[csw_pkg::PIN_SCL] & sda_d_q
                    & ~sync2_q[csw_pkg::PIN_SDA];
  assign stop_ev = scl_d_q & sync2_q[csw_pkg::PIN_SCL] & ~sda_d_q
                   & sync2_q[csw_pkg::PIN_SDA];

  // Read-back byte of the control register
  assign status[csw_pkg::BIT_DLY_HI] = dly_q[1];
  assign status[csw_pkg::BIT_MON2] = mon2_flag_q;
  assign status[csw_pkg::BIT_MON3] = mon3_flag_q;
  assign status[csw_pkg::BIT_LOCK_HI] = lock_q[1];
  assign status[csw_pkg::BIT_LOCK_LO] = lock_q[0];
  assign status[csw_pkg::BIT_REGISTER_WRITE_LATCH] = register_write_latch_q;
  assign status[csw_pkg::BIT_WEL] = wel_q;
  assign status[csw_pkg::BIT_DLY_LO] = dly_q[0];

  // Serial protocol engine: address, register address, data and read-back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= csw_pkg::ST_IDLE;
      nxt_q <= csw_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      data_q <= 8'h00;
      oe_q <= 1'b0;
      ptr_ok_q <= 1'b0;
      got_q <= 1'b0;
      commit_q <= 1'b0;
    end else begin
      commit_q <= 1'b0;
      if (stop_ev) begin
        // The stop's own clock rise may count one bit, never two
        if (st_q == csw_pkg::ST_WDATA && got_q && cnt_q < 4'h2) begin
          commit_q <= 1'b1;
        end
        st_q <= csw_pkg::ST_IDLE;
        got_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (start_ev) begin
        st_q <= csw_pkg::ST_ADDR;
        cnt_q <= 4'h0;
        got_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (rise_ev && (st_q == csw_pkg::ST_ADDR || st_q == csw_pkg::ST_REG
                               || st_q == csw_pkg::ST_WDATA)) begin
        sh_q <= {sh_q[6:0], lbit_q};
        cnt_q <= cnt_q + 4'h1;
      end else if (fall_ev) begin
        case (st_q)
          csw_pkg::ST_ADDR: begin
            if (cnt_q == 4'h8) begin
              if (!busy_q && sh_q == csw_pkg::DEV_WR) begin
                oe_q <= 1'b1;
                st_q <= csw_pkg::ST_ACK;
                nxt_q <= csw_pkg::ST_REG;
              end else if (!busy_q && ptr_ok_q && sh_q == csw_pkg::DEV_RD) begin
                oe_q <= 1'b1;
                st_q <= csw_pkg::ST_ACK;
                nxt_q <= csw_pkg::ST_RDATA;
              end else begin
                st_q <= csw_pkg::ST_IDLE;
                ptr_ok_q <= 1'b0;
              end
            end
          end
          csw_pkg::ST_REG: begin
            if (cnt_q == 4'h8) begin
              if (sh_q == csw_pkg::REG_ADDR) begin
                oe_q <= 1'b1;
                st_q <= csw_pkg::ST_ACK;
                nxt_q <= csw_pkg::ST_WDATA;
                ptr_ok_q <= 1'b1;
              end else begin
                st_q <= csw_pkg::ST_IDLE;
                ptr_ok_q <= 1'b0;
              end
            end
          end
          csw_pkg::ST_WDATA: begin
            if (cnt_q == 4'h8) begin
              // The enabling byte itself must pass while the enable latch is clear
              if (!got_q && (wel_q || sh_q == (8'h01 << csw_pkg::BIT_WEL))) begin
                oe_q <= 1'b1;
                st_q <= csw_pkg::ST_ACK;
                nxt_q <= csw_pkg::ST_WDATA;
                got_q <= 1'b1;
                data_q <= sh_q;
              end else begin
                st_q <= csw_pkg::ST_IDLE;
                got_q <= 1'b0;
              end
            end
          end
          csw_pkg::ST_ACK: begin
            cnt_q <= 4'h0;
            if (nxt_q == csw_pkg::ST_RDATA) begin
              oe_q <= ~status[7];
              rd_q <= {status[6:0], 1'b0};
              cnt_q <= 4'h1;
            end else begin
              oe_q <= 1'b0;
            end
            st_q <= nxt_q;
          end
          csw_pkg::ST_RDATA: begin
            if (cnt_q == 4'h8) begin
              oe_q <= 1'b0;
              st_q <= csw_pkg::ST_RACK;
            end else begin
              oe_q <= ~rd_q[7];
              rd_q <= {rd_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          csw_pkg::ST_RACK: begin
            st_q <= csw_pkg::ST_IDLE;
            ptr_ok_q <= 1'b0;
          end
          default: begin
            st_q <= csw_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  // Latches, flags, retained fields and store timer (reads leave them alone)
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wel_q <= 1'b0;
      register_write_latch_q <= 1'b0;
      mon2_flag_q <= 1'b0;
      mon3_flag_q <= 1'b0;
      lock_q <= csw_pkg::LOCK_RST;
      dly_q <= csw_pkg::DLY_RST;
      busy_q <= 1'b0;
      bcnt_q <= '0;
    end else begin
      if (busy_q) begin
        if (bcnt_q == '0) begin
          busy_q <= 1'b0;
          register_write_latch_q <= 1'b0;
        end else begin
          bcnt_q <= bcnt_q - 1'b1;
        end
      end
      // Locked array attempt clears the latch; a commit in the same cycle wins unless it starts a store
      if (wr_req && !wr_to_pot && locked_addr) begin
        register_write_latch_q <= 1'b0;
      end
      if (commit_q) begin
        wel_q <= data_q[csw_pkg::BIT_WEL];
        if (!register_write_latch_q) begin
          register_write_latch_q <= data_q[csw_pkg::BIT_REGISTER_WRITE_LATCH] & data_q[csw_pkg::BIT_WEL];
        end else if (data_q[csw_pkg::BIT_REGISTER_WRITE_LATCH]) begin
          register_write_latch_q <= 1'b1;
        end else begin
          mon2_flag_q <= data_q[csw_pkg::BIT_MON2] & mon2_s;
          mon3_flag_q <= data_q[csw_pkg::BIT_MON3] & mon3_s;
          if (!wp_s) begin
            lock_q <= {data_q[csw_pkg::BIT_LOCK_HI], data_q[csw_pkg::BIT_LOCK_LO]};
            dly_q <= {data_q[csw_pkg::BIT_DLY_HI], data_q[csw_pkg::BIT_DLY_LO]};
            busy_q <= 1'b1;
            bcnt_q <= csw_pkg::csw_cnt_t'(STORE_CYC - 1);
          end else begin
            register_write_latch_q <= 1'b0;
          end
        end
      end
      if (!mon2_s) begin
        mon2_flag_q <= 1'b0;
      end
      if (!mon3_s) begin
        mon3_flag_q <= 1'b0;
      end
    end
  end

  // Protected array range for the current lock setting
  always_comb begin
    case (lock_q)
      2'h0: locked_addr = 1'b0;
      2'h1: locked_addr = wr_addr >= csw_pkg::LOCK_QTR_BASE;
      2'h2: locked_addr = wr_addr >= csw_pkg::LOCK_HALF_BASE;
      default: locked_addr = 1'b1;
    endcase
  end

  // Leave for array and wiper writes
  assign allow = wel_q && !busy_q
                 && !(wr_nonvol && wp_s)
                 && (wr_to_pot ? (lock_q == 2'h0) : !locked_addr);

  // One-cycle answer to each write request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grant_q <= 1'b0;
      deny_q <= 1'b0;
    end else begin
      grant_q <= wr_req & allow;
      deny_q <= wr_req & ~allow;
    end
  end

  // Hold time selected by the delay field
  always_comb begin
    case (dly_q)
      2'h0: hold_lim = csw_pkg::csw_cnt_t'(HOLD0_CYC);
      2'h1: hold_lim = csw_pkg::csw_cnt_t'(HOLD1_CYC);
      2'h2: hold_lim = csw_pkg::csw_cnt_t'(HOLD2_CYC);
      default: hold_lim = csw_pkg::csw_cnt_t'(HOLD3_CYC);
    endcase
  end

  // Supply reset: high until supply good and manual reset low for hold time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_cnt_q <= '0;
      sro_q <= 1'b1;
    end else if (!sync2_q[csw_pkg::PIN_SUP] || sync2_q[csw_pkg::PIN_MR]) begin
      por_cnt_q <= '0;
      sro_q <= 1'b1;
    end else if (!sro_q || por_cnt_q >= hold_lim) begin
      // Once released, a later change of the delay field must not re-assert it
      sro_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_q + 1'b1;
      sro_q <= 1'b1;
    end
  end

  // Outputs, each from a flip-flop
  assign sda_out = sda_o_q;
  assign sda_oe = oe_q;
  assign wr_grant = grant_q;
  assign wr_deny = deny_q;
  assign supply_reset_out = sro_q;
  assign lock_part = lock_q;
  assign reset_delay_sel = dly_q;
  assign store_busy = busy_q;
  assign write_enable_latch = wel_q;
  assign register_write_latch = register_write_latch_q;

endmodule : csw_ctrl

// File: csw_host_bfm.sv
/* Two-wire host model: moves the link clock only inside frames, pulls data low.
   Assumes a pull-up resolves the data line outside. */
`timescale 1ns/10ps
module csw_host_bfm (
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda_line
);
  // Bus idle: clock high and still, data released
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // One link clock: data set while low, line sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    #20 sda_pull = ~b;
    #60 scl_clk = 1'b1;
    #40 s = sda_line;
    #40 scl_clk = 1'b0;
  endtask : bit_io

  // Start, or repeated start from clock low
  task automatic start(input logic rep);
    if (rep) begin
      #20 sda_pull = 1'b0;
      #60 scl_clk = 1'b1;
    end
    #80 sda_pull = 1'b1;
    #80 scl_clk = 1'b0;
  endtask : start

  // Stop after a ninth clock; the clock then stands high
  task automatic stop();
    #20 sda_pull = 1'b1;
    #60 scl_clk = 1'b1;
    #80 sda_pull = 1'b0;
    #80;
  endtask : stop

  // Byte MSB first, then a released ninth clock; r[0] is the ack level
  task automatic xfer(input logic [7:0] d, output logic [8:0] r);
    logic [8:0] w;
    w = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
  endtask : xfer
endmodule : csw_host_bfm

// File: csw_ctrl_chk.sv
/* Checker on csw_ctrl ports: leave answers, refusals, reset hold, store.
   Assumes it is bound to every csw_ctrl instance. */
`timescale 1ns/10ps
module csw_ctrl_chk #(
  parameter int unsigned HOLD0_CYC = 50,
  parameter int unsigned HOLD1_CYC = 100,
  parameter int unsigned HOLD2_CYC = 200,
  parameter int unsigned HOLD3_CYC = 300,
  parameter int unsigned STORE_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic write_protect_in,
  input wire logic supply_ok_in,
  input wire logic manual_reset_in,
  input wire logic wr_req,
  input wire logic [7:0] wr_addr,
  input wire logic wr_to_pot,
  input wire logic wr_nonvol,
  input wire logic wr_grant,
  input wire logic wr_deny,
  input wire logic supply_reset_out,
  input wire logic [1:0] lock_part,
  input wire logic [1:0] reset_delay_sel,
  input wire logic store_busy,
  input wire logic register_write_latch,
  input wire logic write_enable_latch
);
  logic [31:0] ok_cnt_q, busy_cnt_q, hold_cyc;
  logic in_lock;

  // Cycles with supply good and no manual reset; cycles of store busy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ok_cnt_q <= 32'h0;
      busy_cnt_q <= 32'h0;
    end else begin
      ok_cnt_q <= (supply_ok_in && !manual_reset_in) ? ok_cnt_q + 32'h1 : 32'h0;
      busy_cnt_q <= store_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end

  // Selected hold and locked array range
  always_comb begin
    case (reset_delay_sel)
      2'h0: hold_cyc = HOLD0_CYC;
      2'h1: hold_cyc = HOLD1_CYC;
      2'h2: hold_cyc = HOLD2_CYC;
      default: hold_cyc = HOLD3_CYC;
    endcase
  end
  assign in_lock = lock_part == 2'h3 || (lock_part == 2'h2 && wr_addr[7]) ||
    (lock_part == 2'h1 && wr_addr >= 8'hc0);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_leave_answer: assert property (wr_req |=> wr_grant != wr_deny)
    else $error("leave request not answered by one pulse");
  a_no_wel_deny: assert property (wr_req && !write_enable_latch |=> wr_deny)
    else $error("write allowed with enable latch clear");
  a_wiper_lock: assert property (wr_req && wr_to_pot && lock_part != 2'h0 |=> wr_deny)
    else $error("wiper write allowed under lock");
  a_lock_range: assert property (wr_req && !wr_to_pot && in_lock |=> wr_deny)
    else $error("locked array write allowed");
  a_lock_register_write_latch: assert property (wr_req && !wr_to_pot && in_lock |-> ##[1:2] !register_write_latch)
    else $error("register latch kept after locked write");
  a_protect_nv: assert property (wr_req && wr_nonvol && write_protect_in &&
    $past(write_protect_in, 3) |=> wr_deny)
    else $error("nonvolatile write allowed while protected");
  a_mr_force: assert property (manual_reset_in [*5] |-> supply_reset_out)
    else $error("manual reset did not force supply reset");
  a_supply_low: assert property (!supply_ok_in [*5] |-> supply_reset_out)
    else $error("supply reset low with supply low");
  a_hold_time: assert property ($fell(supply_reset_out) |-> ok_cnt_q >= hold_cyc &&
    ok_cnt_q <= hold_cyc + 32'h8)
    else $error("supply reset hold time wrong");
  a_store_len: assert property ($fell(store_busy) |-> busy_cnt_q + 32'h2 >= STORE_CYC &&
    busy_cnt_q <= STORE_CYC + 32'h2)
    else $error("store busy length wrong");

  c_grant: cover property (wr_req ##1 wr_grant);
  c_store: cover property ($fell(store_busy));
  c_hold3: cover property ($fell(supply_reset_out) && reset_delay_sel == 2'h3);
endmodule : csw_ctrl_chk

bind csw_ctrl csw_ctrl_chk #(.HOLD0_CYC(HOLD0_CYC), .HOLD1_CYC(HOLD1_CYC),
  .HOLD2_CYC(HOLD2_CYC), .HOLD3_CYC(HOLD3_CYC), .STORE_CYC(STORE_CYC)) chk_u (
  .clk_sys, .rst, .write_protect_in, .supply_ok_in, .manual_reset_in, .wr_req, .wr_addr,
  .wr_to_pot, .wr_nonvol, .wr_grant, .wr_deny, .supply_reset_out, .lock_part,
  .reset_delay_sel, .store_busy, .register_write_latch, .write_enable_latch
);

// File: csw_ctrl_tb_top.sv
/* Testbench for csw_ctrl: register traffic via the host model, leave requests,
   reset hold. Assumes csw_pkg, the host model and the checker. */
`timescale 1ns/10ps
module csw_ctrl_tb_top;
  localparam int HOLD_TAB [4] = '{50, 100, 200, 300};
  localparam logic [7:0] CORNER [4] = '{8'hbf, 8'hc0, 8'h7f, 8'h80};
  logic clk_sys, rst, scl_clk, sda_pull, sda_line, sda_out, sda_oe, wr_req, wr_to_pot;
  logic write_protect_in, supply_ok_in, manual_reset_in, monitor2_reset_out, monitor3_reset_out;
  logic wr_nonvol, wr_grant, wr_deny, supply_reset_out, store_busy;
  logic write_enable_latch, register_write_latch, e_wel, e_register_write_latch, e_m2, e_m3;
  logic [1:0] lock_part, reset_delay_sel, e_lock, e_dly;
  logic [7:0] wr_addr;
  logic [3:0] ack;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  // Open-drain data line with pull-up
  assign sda_line = !(sda_pull || (sda_oe && !sda_out));

  csw_ctrl #(.HOLD0_CYC(HOLD_TAB[0]), .HOLD1_CYC(HOLD_TAB[1]), .HOLD2_CYC(HOLD_TAB[2]),
    .HOLD3_CYC(HOLD_TAB[3]), .STORE_CYC(20)) dut_u (
    .clk_sys, .rst, .scl_clk, .sda_in(sda_line), .sda_out, .sda_oe, .write_protect_in,
    .supply_ok_in, .manual_reset_in, .monitor2_reset_out, .monitor3_reset_out, .wr_req,
    .wr_addr, .wr_to_pot, .wr_nonvol, .wr_grant, .wr_deny, .supply_reset_out, .lock_part,
    .reset_delay_sel, .store_busy, .write_enable_latch, .register_write_latch
  );
  csw_host_bfm host_u (.scl_clk, .sda_pull, .sda_line);

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic lk_exp(input logic [7:0] a);
    lk_exp = e_lock == 2'h3 || (e_lock == 2'h2 && a[7]) || (e_lock == 2'h1 && a >= 8'hc0);
  endfunction : lk_exp

  // Control write; ack gathers three ack levels, a fourth in ack[0] when two is set
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic two);
    logic [8:0] r;
    host_u.start(1'b0);
    host_u.xfer(csw_pkg::DEV_WR, r);
    ack[3] = r[0];
    host_u.xfer(a, r);
    ack[2] = r[0];
    host_u.xfer(d, r);
    ack[1] = r[0];
    ack[0] = 1'b1;
    if (two) begin
      host_u.xfer(d, r);
      ack[0] = r[0];
    end
    host_u.stop();
  endtask : reg_wr

  // Write with random monitor levels, update the expected fields, compare ports
  task automatic wr_chk(input logic [7:0] d, input logic two);
    logic ok;
    @(negedge clk_sys);
    monitor2_reset_out = 1'($urandom);
    monitor3_reset_out = 1'($urandom);
    e_m2 = e_m2 & monitor2_reset_out;
    e_m3 = e_m3 & monitor3_reset_out;
    ok = e_wel || d == 8'h02;
    reg_wr(csw_pkg::REG_ADDR, d, two);
    chk("acks", {12'h0, 2'b00, !ok, 1'b1}, {12'h0, ack});
    if (ok && !two) begin
      if (e_register_write_latch && !d[2]) begin
        e_m2 = d[6] & monitor2_reset_out;
        e_m3 = d[5] & monitor3_reset_out;
        if (!write_protect_in) begin
          e_lock = d[4:3];
          e_dly = {d[7], d[0]};
        end
        e_register_write_latch = 1'b0;
      end else begin
        e_register_write_latch = e_register_write_latch | (d[1] & d[2]);
      end
      e_wel = d[1];
    end
    repeat (40) @(negedge clk_sys);
    chk("fields", {8'h0, e_lock, e_dly, 2'b00, e_register_write_latch, e_wel}, {8'h0, lock_part,
      reset_delay_sel, 2'b00, register_write_latch, write_enable_latch});
  endtask : wr_chk

  // Random read of the register
  task automatic rd_chk();
    logic [8:0] r;
    host_u.start(1'b0);
    host_u.xfer(csw_pkg::DEV_WR, r);
    host_u.xfer(csw_pkg::REG_ADDR, r);
    host_u.start(1'b1);
    host_u.xfer(csw_pkg::DEV_RD, r);
    chk("rd_ack", 16'h0, {15'h0, r[0]});
    host_u.xfer(8'hff, r);
    host_u.stop();
    chk("rd_byte", {8'h0, e_dly[1], e_m2, e_m3, e_lock, e_register_write_latch, e_wel, e_dly[0]},
      {8'h0, r[8:1]});
  endtask : rd_chk

  // One leave request with random target kind
  task automatic leave(input logic [7:0] a);
    @(negedge clk_sys);
    wr_req = 1'b1;
    wr_addr = a;
    wr_to_pot = 1'($urandom);
    wr_nonvol = 1'($urandom);
    @(negedge clk_sys);
    wr_req = 1'b0;
    chk("grant", {15'h0, e_wel && !(wr_nonvol && write_protect_in) &&
      !(wr_to_pot ? e_lock != 2'h0 : lk_exp(a))}, {15'h0, wr_grant});
    e_register_write_latch = e_register_write_latch && (wr_to_pot || !lk_exp(a));
  endtask : leave

  // Force supply reset by supply low or manual reset, then time its release
  task automatic hold_chk(input logic use_mr);
    int n;
    @(negedge clk_sys);
    manual_reset_in = use_mr;
    supply_ok_in = use_mr;
    repeat (8) @(negedge clk_sys);
    chk("forced", 16'h1, {15'h0, supply_reset_out});
    manual_reset_in = 1'b0;
    supply_ok_in = 1'b1;
    n = 0;
    while (supply_reset_out !== 1'b0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk("hold", 16'h1, {15'h0, n >= HOLD_TAB[e_dly] && n <= HOLD_TAB[e_dly] + 8});
  endtask : hold_chk

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(71));
    {rst, write_protect_in, supply_ok_in, manual_reset_in, monitor2_reset_out} = 5'b10100;
    {monitor3_reset_out, wr_req, wr_to_pot, wr_nonvol, wr_addr} = 12'h0;
    {e_lock, e_dly, e_wel, e_register_write_latch, e_m2, e_m3} = 8'h10;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    hold_chk(1'b0);
    rd_chk();
    wr_chk(8'h00, 1'b0);
    reg_wr(8'hfe, 8'h02, 1'b0);
    chk("bad_addr", 16'h7, {12'h0, ack});
    for (int i = 3; i >= 0; i--) begin
      wr_chk(8'h02, 1'b0);
      wr_chk(8'h06, 1'b0);
      rd_chk();
      wr_chk({i[1], 2'b11, i[1:0], 2'b01, i[0]}, 1'b0);
      wr_chk(8'h02, 1'b0);
      wr_chk(8'h06, 1'b0);
      for (int j = 0; j < 8; j++) leave(j < 4 ? CORNER[j] : 8'($urandom));
      chk("register_write_latch", {15'h0, e_register_write_latch}, {15'h0, register_write_latch});
      hold_chk(i[0]);
      rd_chk();
    end
    wr_chk(8'hff, 1'b0);
    @(negedge clk_sys);
    write_protect_in = 1'b1;
    wr_chk(8'h9b, 1'b0);
    for (int j = 0; j < 6; j++) leave(8'($urandom));
    rd_chk();
    @(negedge clk_sys);
    write_protect_in = 1'b0;
    wr_chk(8'h06, 1'b0);
    wr_chk(8'h9a, 1'b1);
    wr_chk(8'h00, 1'b0);
    wr_chk(8'h00, 1'b0);
    rd_chk();
    end_sim();
  end
endmodule : csw_ctrl_tb_top
